// ---- rtl/dcwg_pkg.sv ----
// package of offsets, field positions and reset values for the debug control write guard
package dcwg_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL_ONE = 12'h0100;  // debug_control_one
  localparam logic [11:0] ADDR_STATUS = 12'h0104;    // sticky event flags, read clears
  localparam logic [11:0] ADDR_MASK = 12'h0108;      // interrupt mask, same layout as status
  // ----------------------------------------------------------------
  // field positions of debug_control_one
  // ----------------------------------------------------------------
  localparam int BIT_ARM = 7;       // session-active bit
  localparam int BIT_FORCE_TRIGGER_BIT = 6;      // force_trigger_bit, write only
  localparam int CFG_HI = 5;        // top of the configuration field
  localparam int CFG_W = 6;         // width of the configuration field
  localparam int CTRL_W = 8;        // register width
  // ----------------------------------------------------------------
  // status and mask layout
  // ----------------------------------------------------------------
  localparam int EVT_W = 3;         // number of event flags
  localparam int EVT_DISARM = 0;    // hardware disarm seen
  localparam int EVT_REFUSED = 1;   // arm attempt refused
  localparam int EVT_BREAK = 2;     // breakpoint raised
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // apb bus state
  typedef enum logic [1:0] {
    DCWG_IDLE = 2'b01,
    DCWG_ACC = 2'b10
  } dcwg_bus_e;
endpackage : dcwg_pkg

// ---- rtl/dcwg_sync.sv ----
// two-flop synchroniser for event inputs from outside the clock domain
`timescale 1ns/10ps
module dcwg_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;  // first stage, read only by the second
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    next_meta = d_in;
    next_q = meta;
  end
  // registers
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= next_meta;
      q_out <= next_q;
    end
  end
endmodule : dcwg_sync

// ---- rtl/dcwg_top.sv ----
// debug control write guard: apb register, write qualification, disarm priority, interrupt
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
// Behaviour
// RULE1 - armed: only arm and trigger bits writable
// RULE2 - arm cannot be set while profiling active
// RULE3 - trigger bit writable, always reads zero
// RULE4 - config bits writable only disarmed, not profiling
// RULE5 - hardware disarm beats write, raises breakpoint
// RULE6 - software disarm leaves config bits unchanged
// RULE7 - reset clears arm bit
module dcwg_top (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // debug module internals (asynchronous sources)
  input wire logic profiling_in_progress_in,
  input wire logic hw_disarm_in,
  input wire logic brk_enable_in,
  // debug module controls
  output logic armed_out,
  output logic force_trigger_bit_out,
  output logic [dcwg_pkg::CFG_W-1:0] cfg_out,
  output logic breakpoint_out,
  // interrupt
  output logic irq_out
);
  import dcwg_pkg::*;

  // ----------------------------------------------------------------
  // synchronised inputs
  // ----------------------------------------------------------------
  logic [2:0] sync_q;   // {brk enable, disarm, profiling}
  logic prof_act;       // profiling active, synchronised
  logic disarm_lvl;     // disarm level, synchronised
  logic disarm_d;       // delayed copy for edge detect
  logic disarm_ev;      // one-cycle hardware disarm event
  logic brk_en;         // breakpoint enable, synchronised

  // the three sources belong to other parts of the debug module that may sit on
  // another clock, so each passes two flops; disarm and profiling therefore act
  // two cycles late, which software cannot observe over the bus
  dcwg_sync #(.W(3)) dcwg_sync_i (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .d_in({brk_enable_in, hw_disarm_in, profiling_in_progress_in}),
    .q_out(sync_q)
  );

  // bundle order: bit 0 profiling, bit 1 disarm, bit 2 breakpoint enable
  assign prof_act = sync_q[0];
  assign disarm_lvl = sync_q[1];
  assign brk_en = sync_q[2];
  // rising edge only, so a held disarm does not keep refusing arming
  assign disarm_ev = disarm_lvl & ~disarm_d;
  // limitation: the disarm source must stay high for two clock periods or the
  // synchroniser may miss it, and it must fall again before a new event counts

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  dcwg_bus_e state;       // bus phase tracker
  dcwg_bus_e next_state;
  logic acc;              // access phase qualified
  logic wr_ctrl;          // write strobe to control register
  logic rd_stat;          // read of status, clears it
  logic wr_mask;          // write strobe to mask
  logic mapped;           // address hits a register

  // address match used by several strobes; one comparator shape for every
  // decode, so a new register costs one line
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  // the slave never stretches a transfer, so access phase and ready coincide
  assign acc = psel_in & penable_in;
  assign mapped = hit(paddr_in, ADDR_CTRL_ONE) | hit(paddr_in, ADDR_STATUS) | hit(paddr_in, ADDR_MASK);
  assign wr_ctrl = acc & pwrite_in & hit(paddr_in, ADDR_CTRL_ONE);
  assign wr_mask = acc & pwrite_in & hit(paddr_in, ADDR_MASK);
  assign rd_stat = acc & ~pwrite_in & hit(paddr_in, ADDR_STATUS);
  // zero wait states; unmapped addresses answer with an error
  assign pready_out = acc;
  assign pslverr_out = acc & ~mapped;

  // bus phase tracking; the assertions use it to check that every access
  // phase was preceded by its setup cycle
  always_comb begin
    next_state = state;
    case (state)
      DCWG_IDLE: begin
        if (psel_in && !penable_in) begin
          next_state = DCWG_ACC;
        end
      end
      DCWG_ACC: begin
        if (acc) begin
          next_state = DCWG_IDLE;
        end
      end
      default: begin
        next_state = DCWG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // control register with write qualification
  // ----------------------------------------------------------------
  logic arm;                       // session-active bit
  logic force_trigger_bit;                      // one-cycle force trigger pulse
  logic [CFG_W-1:0] cfg;           // configuration bits
  logic brk;                       // breakpoint pulse
  logic next_arm;
  logic next_force_trigger_bit;
  logic [CFG_W-1:0] next_cfg;
  logic next_brk;
  logic refused;                   // arm attempt blocked this cycle
  logic [CTRL_W-1:0] wd;           // write data byte

  assign wd = pwdata_in[CTRL_W-1:0];

  // one decision per cycle: hardware disarm first, then the software write;
  // the trigger pulse sits outside that chain so a write never loses it,
  // even when a disarm takes the arm bit in the same cycle
  always_comb begin
    next_arm = arm;
    next_cfg = cfg;
    next_force_trigger_bit = 1'b0;
    next_brk = 1'b0;
    refused = 1'b0;
    if (disarm_ev) begin
      // hardware disarm wins over any write in the same cycle
      next_arm = 1'b0;                                      // RULE5
      next_brk = brk_en;                                    // RULE5
    end else if (wr_ctrl) begin
      // arm may be written while armed; setting blocked by profiling
      if (wd[BIT_ARM] && prof_act) begin
        refused = 1'b1;                                     // RULE2
      end else begin
        next_arm = wd[BIT_ARM];                             // RULE1
      end
      // config only while disarmed beforehand and not profiling, so a
      // software disarm leaves the field as it was
      if (!arm && !prof_act) begin
        next_cfg = wd[CFG_HI:0];                            // RULE4 RULE6
      end
    end
    // trigger accepted at any time, even alongside a disarm
    if (wr_ctrl) begin
      next_force_trigger_bit = wd[BIT_FORCE_TRIGGER_BIT];                             // RULE3 RULE1
    end
  end

  // ----------------------------------------------------------------
  // interrupt flags: set wins over read-clear
  // ----------------------------------------------------------------
  logic [EVT_W-1:0] stat;
  logic [EVT_W-1:0] mask;
  logic [EVT_W-1:0] next_stat;
  logic [EVT_W-1:0] next_mask;
  logic [EVT_W-1:0] evt;

  // read-clear is applied before the or with new events, so an event that
  // lands in the read cycle survives until the next read
  always_comb begin
    evt = '0;
    evt[EVT_DISARM] = disarm_ev;
    evt[EVT_REFUSED] = refused;
    evt[EVT_BREAK] = next_brk;
    next_stat = (rd_stat ? '0 : stat) | evt;
    next_mask = wr_mask ? pwdata_in[EVT_W-1:0] : mask;
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;   // read word for the current access
  // decoded straight from the registers so that zero wait states still return
  // current data; the cost is a combinational path from paddr to prdata

  always_comb begin
    next_rdata = RDATA_ZERO;
    if (acc && !pwrite_in) begin
      if (hit(paddr_in, ADDR_CTRL_ONE)) begin
        // trigger bit always reads as zero
        next_rdata[BIT_ARM] = arm;                          // RULE3
        next_rdata[CFG_HI:0] = cfg;
      end else if (hit(paddr_in, ADDR_STATUS)) begin
        next_rdata[EVT_W-1:0] = stat;
      end else if (hit(paddr_in, ADDR_MASK)) begin
        next_rdata[EVT_W-1:0] = mask;
      end
    end
  end

  // read data must be valid in the access cycle itself
  assign prdata_out = next_rdata;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one register process for all bus, control and flag state
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= DCWG_IDLE;
      arm <= CTRL_RST[BIT_ARM];                             // RULE7
      cfg <= CTRL_RST[CFG_HI:0];
      force_trigger_bit <= 1'b0;
      brk <= 1'b0;
      stat <= EVT_RST;
      mask <= EVT_RST;
      disarm_d <= 1'b0;
    end else begin
      state <= next_state;
      arm <= next_arm;
      cfg <= next_cfg;
      force_trigger_bit <= next_force_trigger_bit;
      brk <= next_brk;
      stat <= next_stat;
      mask <= next_mask;
      disarm_d <= disarm_lvl;
    end
  end

  // control outputs come straight from flops; only the interrupt adds an
  // and-or of two registers, which keeps it glitch-light and level only,
  // so the consumer must not treat it as an edge
  assign armed_out = arm;
  assign force_trigger_bit_out = force_trigger_bit;
  assign cfg_out = cfg;
  assign breakpoint_out = brk;
  assign irq_out = |(stat & mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_cfg_locked_armed: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE1
    (arm || prof_act) |=> $stable(cfg)) else $error("config changed while locked");
  a_no_arm_profiling: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE2
    (prof_act && !arm) |=> !arm) else $error("armed during profiling");
  a_force_trigger_bit_reads_zero: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE3
    (acc && !pwrite_in && paddr_in == ADDR_CTRL_ONE) |-> !prdata_out[BIT_FORCE_TRIGGER_BIT])
    else $error("trigger bit read nonzero");
  a_force_trigger_bit_pulse: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE3
    (wr_ctrl && wd[BIT_FORCE_TRIGGER_BIT]) |=> force_trigger_bit_out ##1 !force_trigger_bit_out)
    else $error("trigger not a single pulse");
  a_cfg_write_open: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE4
    (wr_ctrl && !arm && !prof_act && !disarm_ev) |=> cfg == $past(wd[CFG_HI:0]))
    else $error("config write lost");
  a_disarm_wins: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE5
    disarm_ev |=> !arm && (breakpoint_out == $past(brk_en)))
    else $error("hardware disarm lost");
  a_sw_disarm_keep: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE6
    (wr_ctrl && arm && !wd[BIT_ARM]) |=> $stable(cfg))
    else $error("config altered by disarm");
  a_irq_level: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE5
    disarm_ev && mask[EVT_DISARM] |=> irq_out)
    else $error("interrupt missing");
  a_reset_disarmed: assert property (@(posedge ref_clk_in) // RULE7
    $rose(nrst_in) |-> !arm) else $error("armed after reset");
  // ----------------------------------------------------------------
  // bus protocol checks
  // ----------------------------------------------------------------
  a_setup_first: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    acc |-> (state == DCWG_ACC)) else $error("access without setup");
  a_slverr_unmapped: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (acc && !mapped) |-> (pslverr_out && (prdata_out == RDATA_ZERO)))
    else $error("unmapped access not flagged");
  a_prdata_idle: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (!acc || pwrite_in) |-> (prdata_out == RDATA_ZERO)) else $error("read data outside read access");
  // ----------------------------------------------------------------
  // further control checks
  // ----------------------------------------------------------------
  a_arm_clear_ok: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE1
    (wr_ctrl && !wd[BIT_ARM]) |=> !arm) else $error("arm clear lost");
  a_arm_set_path: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE2
    $rose(arm) |-> ($past(wr_ctrl) && !$past(prof_act))) else $error("arm set without a legal write");
  a_refuse_flag: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE2
    (wr_ctrl && wd[BIT_ARM] && prof_act && !disarm_ev) |=> stat[EVT_REFUSED])
    else $error("refused arm not flagged");
  a_force_trigger_bit_after_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE3
    force_trigger_bit_out |-> $past(wr_ctrl)) else $error("trigger without a write");
  a_disarm_keeps_cfg: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE5
    disarm_ev |=> $stable(cfg)) else $error("config written during disarm");
  a_brk_needs_en: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE5
    breakpoint_out |-> ($past(disarm_ev) && $past(brk_en))) else $error("breakpoint without enabled disarm");
  // ----------------------------------------------------------------
  // flag checks: set wins over read-clear, mask taken as written
  // ----------------------------------------------------------------
  a_stat_set_wins: assert property (@(posedge ref_clk_in) disable iff (!nrst_in) // RULE5
    (rd_stat && disarm_ev) |=> stat[EVT_DISARM]) else $error("disarm flag lost to read");
  a_stat_read_clear: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (rd_stat && !disarm_ev) |=> (stat == EVT_RST)) else $error("status not cleared by read");
  a_mask_write: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_mask |=> (mask == $past(pwdata_in[EVT_W-1:0]))) else $error("mask write lost");
endmodule : dcwg_top

// ---- dv/dcwg_top_test.sv ----
// self-checking bench for the debug control write guard over apb
`timescale 1ns/10ps
module dcwg_top_test;
  import dcwg_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and design signals
  // ----------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic prof = 1'b0; // profiling_in_progress level
  logic hw_dis = 1'b0; // internal disarm event source
  logic brk_en = 1'b0; // breakpoint enable level
  logic [31:0] prdata;
  logic pready, pslverr, armed, force_trigger_bit, brk, irq;
  logic [CFG_W-1:0] cfg;
  int fail_count = 0;
  int tests_run = 0;
  // 25 MHz clock
  always #20 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  dcwg_top dcwg_top_i (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .profiling_in_progress_in(prof),
    .hw_disarm_in(hw_dis), .brk_enable_in(brk_en), .armed_out(armed),
    .force_trigger_bit_out(force_trigger_bit), .cfg_out(cfg), .breakpoint_out(brk), .irq_out(irq)
  );
  // ----------------------------------------------------------------
  // compare and report tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmpb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask : cmpb
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // apb master: setup, access held until pready sampled high
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // a slave that never answers ends the run
    if (n >= 16) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no pready", $time);
      wrap_up();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp(rd, exp);
  endtask : rdc
  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : waitc
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    int nb;
    waitc(8);
    nrst_in <= 1'b1;
    // reset state: disarmed, register clear
    cmpb(armed, 1'b0);
    rdc(ADDR_CTRL_ONE, 32'h0000_0000);
    $display("test reset done");
    // disarmed: cfg and trigger writable, trigger reads zero
    wr(ADDR_CTRL_ONE, 32'h0000_007F);
    #1 cmpb(force_trigger_bit, 1'b1);
    cmp({26'h0, cfg}, 32'h0000_003F);
    rdc(ADDR_CTRL_ONE, 32'h0000_003F);
    $display("test disarmed writes done");
    // armed: only arm and trigger take effect
    wr(ADDR_CTRL_ONE, 32'h0000_00BF);
    #1 cmpb(armed, 1'b1);
    wr(ADDR_CTRL_ONE, 32'h0000_00C0);
    #1 cmpb(force_trigger_bit, 1'b1);
    rdc(ADDR_CTRL_ONE, 32'h0000_00BF);
    // software disarm keeps cfg, a second write clears it
    wr(ADDR_CTRL_ONE, 32'h0000_0000);
    rdc(ADDR_CTRL_ONE, 32'h0000_003F);
    wr(ADDR_CTRL_ONE, 32'h0000_0000);
    rdc(ADDR_CTRL_ONE, 32'h0000_0000);
    $display("test armed writes done");
    // profiling active: arm and cfg refused, refusal raises irq
    wr(ADDR_MASK, 32'h0000_0007);
    prof <= 1'b1;
    waitc(3);
    wr(ADDR_CTRL_ONE, 32'h0000_0085);
    #1 cmpb(irq, 1'b1);
    rdc(ADDR_CTRL_ONE, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0002);
    #1 cmpb(irq, 1'b0);
    wr(ADDR_MASK, 32'h0000_0000);
    wr(ADDR_CTRL_ONE, 32'h0000_0080);
    #1 cmpb(irq, 1'b0);
    rdc(ADDR_STATUS, 32'h0000_0002);
    prof <= 1'b0;
    waitc(3);
    $display("test profiling refusal done");
    // hardware disarm in the same cycle as a control write
    wr(ADDR_MASK, 32'h0000_0001);
    brk_en <= 1'b1;
    wr(ADDR_CTRL_ONE, 32'h0000_0080);
    hw_dis <= 1'b1;
    wr(ADDR_CTRL_ONE, 32'h0000_0095);
    #1 cmpb(armed, 1'b0);
    cmpb(brk, 1'b1);
    cmpb(irq, 1'b1);
    hw_dis <= 1'b0;
    rdc(ADDR_CTRL_ONE, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0005);
    #1 cmpb(irq, 1'b0);
    // breakpoints disabled: disarm raises none
    brk_en <= 1'b0;
    wr(ADDR_CTRL_ONE, 32'h0000_0080);
    hw_dis <= 1'b1;
    nb = 0;
    repeat (6) begin
      @(posedge ref_clk_in);
      #1 nb = nb + int'(brk === 1'b1);
    end
    hw_dis <= 1'b0;
    cmpb(nb == 0, 1'b1);
    cmpb(armed, 1'b0);
    $display("test hardware disarm done");
    // reset in mid-run while armed
    wr(ADDR_CTRL_ONE, 32'h0000_0080);
    #1 cmpb(armed, 1'b1);
    waitc(1);
    nrst_in <= 1'b0;
    waitc(2);
    cmpb(armed, 1'b0);
    cmp({26'h0, cfg}, 32'h0000_0000);
    nrst_in <= 1'b1;
    $display("test mid-run reset done");
    // unmapped place: error, reads zero
    apb(1'b0, 12'h10C, 32'h0000_0000, rd, err);
    cmp(rd, 32'h0000_0000);
    cmpb(err, 1'b1);
    $display("test unmapped done");
    wrap_up();
  end
endmodule : dcwg_top_test
